// file: inc/admf_regs.svh
// Register offsets, field positions and timing counts of the mode and fault block.
`ifndef ADMF_REGS_SVH
`define ADMF_REGS_SVH
`define ADMF_ADDR_W 4
`define ADMF_OFS_CTRL 4'h0
`define ADMF_OFS_STAT 4'h1
`define ADMF_OFS_WAKE 4'h2
`define ADMF_OFS_SRC 4'h3
`define ADMF_CTRL_MODE_LSB 0
`define ADMF_CTRL_WDCLR 2
`define ADMF_CTRL_SW1 3
`define ADMF_CTRL_SW2 4
`define ADMF_CTRL_SW3 5
`define ADMF_MODE_NORMAL 2'h0
`define ADMF_MODE_STOP 2'h1
`define ADMF_MODE_SLEEP 2'h2
`define ADMF_WD_TIMEOUT_MS 150
`define ADMF_CLK_HZ 40000000
`define ADMF_WD_CYCLES ((`ADMF_WD_TIMEOUT_MS * 64'd40000000) / 64'd1000)
`define ADMF_IRQ_PULSE_CYCLES 8'h28
`define ADMF_RST_HOLD_CYCLES 8'h40
`endif

// file: inc/admf_pkg.sv
// Types shared by the mode and fault block.
package admf_pkg;
    typedef enum logic [4:0] {
        ADMF_RESET = 5'b00001,
        ADMF_NREQ = 5'b00010,
        ADMF_NORMAL = 5'b00100,
        ADMF_STOP = 5'b01000,
        ADMF_SLEEP = 5'b10000
    } admf_mode_e;
    typedef logic [7:0] admf_byte_t;
endpackage

// file: inc/admf_irq_if.sv
// Event strobe carried from the mode controller to the interrupt pulse generator.
`timescale 1ns/100ps
`default_nettype none
interface admf_irq_if;
    logic fire;
    logic pulse_n;
    modport ctrl (output fire, input pulse_n);
    modport gen (input fire, output pulse_n);
endinterface
`default_nettype wire

// file: verilog/admf_irq_pulse.sv
// Fixed-length active-low interrupt pulse generator.
`timescale 1ns/100ps
`default_nettype none
`include "admf_regs.svh"
module admf_irq_pulse (
    input wire logic core_clk,
    input wire logic rst_n,
    admf_irq_if.gen irq
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    wire logic busy = (cnt_q != 8'h00);
    // A new event during a pulse restarts nothing, so every pulse keeps its length.
    assign cnt_d = busy ? 8'(cnt_q - 8'h01) : (irq.fire ? `ADMF_IRQ_PULSE_CYCLES : 8'h00);
    assign irq.pulse_n = ~busy;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // admf_irq_pulse
`default_nettype wire

// file: verilog/admf_mode_ctrl.sv
// Operating-mode sequencer, watchdog and fault/wake interrupt logic.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "admf_regs.svh"
module admf_mode_ctrl #(
    parameter logic [31:0] WD_CYCLES = 32'(`ADMF_WD_CYCLES),
    parameter logic [15:0] BUS_WAKE_CYCLES = 16'h0640
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`ADMF_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output admf_pkg::admf_byte_t reg_rdata,
    input wire logic watchdog_config_pin,
    input wire logic direct_switch_enable,
    input wire logic wake_input_one,
    input wire logic wake_input_two,
    input wire logic bus_rx,
    input wire logic bus_tx,
    input wire logic select_n,
    input wire logic supply_low,
    input wire logic supply_high,
    input wire logic regulator_hot,
    input wire logic switch_hot,
    output logic reset_out_n,
    output logic irq_out_n,
    output logic regulator_on,
    output logic regulator_limited,
    output logic switch_out_one,
    output logic switch_out_two,
    output logic switch_out_three,
    output logic bus_tx_out,
    output logic bus_rx_enable,
    output logic sense_amp_on,
    output logic watchdog_running
);
    import admf_pkg::*;

    admf_irq_if irq_bus ();
    admf_irq_pulse u_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .irq(irq_bus)
    );

    admf_mode_e mode_q;
    admf_mode_e mode_d;
    logic [7:0] rst_cnt_q;
    logic [31:0] wd_cnt_q;
    logic wd_first_q;
    logic [5:0] ctrl_q;
    logic [1:0] src_q;
    logic [3:0] src_code_q;
    logic src_valid_q;
    logic bus_wake_q;
    logic [15:0] dom_cnt_q;
    logic dom_long_q;
    logic rx_q, wk1_q, wk2_q, sel_q;
    logic ovt_latch_q;
    logic [3:0] fault_q;
    logic [7:0] rdata_q;

    // Fault conditions only count when the detectors are powered.
    wire logic detect_on = (mode_q == ADMF_NORMAL) || (mode_q == ADMF_NREQ);
    wire logic [3:0] fault_now = detect_on ?
        {switch_hot, regulator_hot, supply_high, supply_low} : 4'h0;
    wire logic [3:0] fault_rise = fault_now & ~fault_q;
    wire logic fault_evt = (mode_q == ADMF_NORMAL) && (fault_rise != 4'h0);

    function automatic logic [3:0] first_bit(input logic [3:0] v);
        logic [3:0] r;
        r = 4'h0;
        if (v[0]) r = 4'h1;
        else if (v[1]) r = 4'h2;
        else if (v[2]) r = 4'h3;
        else if (v[3]) r = 4'h4;
        return r;
    endfunction

    // Bus wake: dominant longer than the filter time, then a rising edge.
    wire logic bus_rise = bus_rx && !rx_q;
    wire logic bus_wake_evt = bus_rise && dom_long_q;
    wire logic low_power = (mode_q == ADMF_STOP) || (mode_q == ADMF_SLEEP);
    wire logic pin_wake = (wake_input_one != wk1_q) || (wake_input_two != wk2_q);
    wire logic sel_wake = (mode_q == ADMF_STOP) && select_n && !sel_q;
    wire logic stop_wake = (mode_q == ADMF_STOP) &&
        (pin_wake || bus_wake_evt || sel_wake);
    wire logic sleep_wake = (mode_q == ADMF_SLEEP) && (pin_wake || bus_wake_evt);
    wire logic [3:0] wake_code = pin_wake ? 4'h5 : (bus_wake_evt ? 4'h6 : 4'h7);

    wire logic ctrl_wr = reg_wr && (reg_addr == `ADMF_OFS_CTRL);
    wire logic src_rd = reg_rd && (reg_addr == `ADMF_OFS_SRC);
    wire logic stat_rd = reg_rd && (reg_addr == `ADMF_OFS_STAT);
    wire logic [1:0] wr_mode = reg_wdata[`ADMF_CTRL_MODE_LSB +: 2];
    wire logic wd_clear = ctrl_wr && reg_wdata[`ADMF_CTRL_WDCLR];
    wire logic wd_enabled = watchdog_config_pin;
    wire logic [31:0] wd_half = {1'b0, WD_CYCLES[31:1]};
    // Clearing inside the closed first half of the window is a failure, except the first.
    wire logic wd_closed_hit = wd_clear && !wd_first_q && (wd_cnt_q < wd_half);
    wire logic wd_expired = (wd_cnt_q >= WD_CYCLES);
    wire logic wd_active = wd_enabled && ((mode_q == ADMF_NREQ) || (mode_q == ADMF_NORMAL));
    wire logic wd_fail = wd_active && (wd_closed_hit || wd_expired);

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            ADMF_RESET: if (rst_cnt_q == 8'h00) mode_d = ADMF_NREQ;
            ADMF_NREQ: begin
                if (wd_fail) mode_d = ADMF_RESET;
                else if (wd_clear || (ctrl_wr && !wd_enabled)) mode_d = ADMF_NORMAL;
            end
            ADMF_NORMAL: begin
                if (wd_fail) mode_d = ADMF_RESET;
                else if (ctrl_wr && wr_mode == `ADMF_MODE_STOP) mode_d = ADMF_STOP;
                else if (ctrl_wr && wr_mode == `ADMF_MODE_SLEEP) mode_d = ADMF_SLEEP;
            end
            ADMF_STOP: if (stop_wake) mode_d = ADMF_NREQ;
            ADMF_SLEEP: if (sleep_wake) mode_d = ADMF_RESET;
            default: mode_d = ADMF_RESET;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_q <= ADMF_RESET;
            rst_cnt_q <= `ADMF_RST_HOLD_CYCLES;
        end else begin
            mode_q <= mode_d;
            if (mode_d == ADMF_RESET && mode_q != ADMF_RESET) rst_cnt_q <= `ADMF_RST_HOLD_CYCLES;
            else if (rst_cnt_q != 8'h00) rst_cnt_q <= 8'(rst_cnt_q - 8'h01);
        end
    end

    // Watchdog counter restarts on entry to Normal Request and on every legal clear.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wd_cnt_q <= 32'h0;
            wd_first_q <= 1'b1;
        end else if (!wd_active || mode_q != mode_d) begin
            wd_cnt_q <= 32'h0;
            wd_first_q <= (mode_d == ADMF_NREQ);
        end else if (wd_clear) begin
            wd_cnt_q <= 32'h0;
            wd_first_q <= 1'b0;
        end else begin
            wd_cnt_q <= wd_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= 6'h0;
        end else if (mode_q == ADMF_RESET) begin
            ctrl_q <= 6'h0;
        end else if (ctrl_wr) begin
            ctrl_q <= reg_wdata[5:0];
        end
    end

    // Overheat latches all switches off; a new control write re-arms them.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ovt_latch_q <= 1'b0;
        end else if (fault_now[3]) begin
            ovt_latch_q <= 1'b1;
        end else if (ctrl_wr || mode_q == ADMF_RESET) begin
            ovt_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_q <= 1'b1;
            wk1_q <= 1'b0;
            wk2_q <= 1'b0;
            sel_q <= 1'b1;
            dom_cnt_q <= 16'h0;
            dom_long_q <= 1'b0;
            fault_q <= 4'h0;
        end else begin
            rx_q <= bus_rx;
            wk1_q <= wake_input_one;
            wk2_q <= wake_input_two;
            sel_q <= select_n;
            fault_q <= fault_now;
            if (bus_rx) begin
                dom_cnt_q <= 16'h0;
                dom_long_q <= 1'b0;
            end else if (dom_cnt_q >= BUS_WAKE_CYCLES) begin
                dom_long_q <= 1'b1;
            end else begin
                dom_cnt_q <= dom_cnt_q + 16'h1;
            end
        end
    end

    // Source flag: a new event wins over the clearing read in the same cycle.
    wire logic src_evt = fault_evt || stop_wake;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            src_valid_q <= 1'b0;
            src_code_q <= 4'h0;
            bus_wake_q <= 1'b0;
        end else begin
            if (src_evt) begin
                src_valid_q <= 1'b1;
                src_code_q <= fault_evt ? first_bit(fault_rise) : wake_code;
            end else if (src_rd) begin
                src_valid_q <= 1'b0;
            end
            if (bus_wake_evt && low_power) bus_wake_q <= 1'b1;
            else if (stat_rd) bus_wake_q <= 1'b0;
        end
    end
    assign src_q = {1'b0, src_valid_q};
    assign irq_bus.fire = src_evt;

    wire logic in_normal = (mode_q == ADMF_NORMAL);
    wire logic [7:0] rd_mux =
        (reg_addr == `ADMF_OFS_CTRL) ? {2'b00, ctrl_q} :
        (reg_addr == `ADMF_OFS_STAT) ? {3'b000, bus_wake_q, fault_q} :
        (reg_addr == `ADMF_OFS_WAKE) ? (in_normal ? {6'h0, wake_input_two, wake_input_one}
                                                  : 8'h00) :
        (reg_addr == `ADMF_OFS_SRC) ? {3'b000, src_q[0], src_code_q} : 8'h00;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    wire logic sw_allowed = (mode_q == ADMF_NREQ || in_normal) && !ovt_latch_q;
    assign switch_out_one = sw_allowed && ctrl_q[`ADMF_CTRL_SW1] && direct_switch_enable;
    assign switch_out_two = sw_allowed && ctrl_q[`ADMF_CTRL_SW2] && direct_switch_enable;
    assign switch_out_three = sw_allowed && ctrl_q[`ADMF_CTRL_SW3];
    assign reset_out_n = !(mode_q == ADMF_RESET || mode_q == ADMF_SLEEP);
    assign irq_out_n = irq_bus.pulse_n;
    assign regulator_on = (mode_q != ADMF_SLEEP);
    assign regulator_limited = (mode_q == ADMF_STOP);
    wire logic bus_active = (mode_q == ADMF_NREQ) || in_normal;
    assign bus_tx_out = bus_active ? bus_tx : 1'b1;
    assign bus_rx_enable = 1'b1;
    assign sense_amp_on = in_normal;
    assign watchdog_running = wd_active;
endmodule // admf_mode_ctrl
`default_nettype wire

// file: bench/admf_mode_ctrl_sva.sv
// Port-level checks of the mode sequencer and its interrupt pulse.
`timescale 1ns/100ps
`default_nettype none
module admf_mode_ctrl_sva #(
    parameter logic [31:0] WD_CYCLES = 32'h000000c8,
    parameter logic [15:0] BUS_WAKE_CYCLES = 16'h0004
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic watchdog_config_pin,
    input wire logic direct_switch_enable,
    input wire logic supply_low,
    input wire logic switch_hot,
    input wire logic reset_out_n,
    input wire logic irq_out_n,
    input wire logic regulator_on,
    input wire logic regulator_limited,
    input wire logic switch_out_one,
    input wire logic switch_out_two,
    input wire logic switch_out_three,
    input wire logic bus_tx_out,
    input wire logic sense_amp_on,
    input wire logic watchdog_running
);
    // Counts how long the interrupt line has been low.
    logic [7:0] low_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n || irq_out_n) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_q + 8'h01;
        end
    end
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_pulse_len;
        $rose(irq_out_n) |-> low_q == 8'h28;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("irq pulse length wrong");
    property p_pulse_cap;
        !irq_out_n |-> low_q < 8'h28;
    endproperty
    a_pulse_cap: assert property (p_pulse_cap) else $error("irq pulse too long");
    property p_fault_irq;
        sense_amp_on && $rose(supply_low) && irq_out_n |-> ##[1:3] !irq_out_n;
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("no fault pulse");
    property p_sw_gate;
        switch_out_one || switch_out_two |-> direct_switch_enable || $past(direct_switch_enable);
    endproperty
    a_sw_gate: assert property (p_sw_gate) else $error("switch on without enable");
    property p_stop_state;
        regulator_limited |-> regulator_on && bus_tx_out && !sense_amp_on && !watchdog_running;
    endproperty
    a_stop_state: assert property (p_stop_state) else $error("bad low power state");
    property p_sleep_state;
        !regulator_on |-> !reset_out_n && bus_tx_out && !switch_out_three;
    endproperty
    a_sleep_state: assert property (p_sleep_state) else $error("bad sleep state");
    property p_reset_state;
        !reset_out_n |-> !sense_amp_on && !switch_out_one && !switch_out_two && !switch_out_three;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    property p_wd_off;
        !watchdog_config_pin [*3] |-> !watchdog_running;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog runs while disabled");
    property p_hot_off;
        $rose(switch_hot) |-> ##[1:3] !(switch_out_one || switch_out_two || switch_out_three);
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("switches stay on when hot");
    property p_normal;
        sense_amp_on |-> reset_out_n && regulator_on && !regulator_limited;
    endproperty
    a_normal: assert property (p_normal) else $error("sense amp on outside run");
endmodule // admf_mode_ctrl_sva
bind admf_mode_ctrl admf_mode_ctrl_sva #(.WD_CYCLES(WD_CYCLES),
    .BUS_WAKE_CYCLES(BUS_WAKE_CYCLES)) u_sva (.core_clk, .rst_n, .watchdog_config_pin,
    .direct_switch_enable, .supply_low, .switch_hot, .reset_out_n, .irq_out_n, .regulator_on,
    .regulator_limited, .switch_out_one, .switch_out_two, .switch_out_three, .bus_tx_out,
    .sense_amp_on, .watchdog_running);
`default_nettype wire

// file: bench/admf_mcu_model.sv
// Controller-side model that counts and times interrupt pulses.
`timescale 1ns/100ps
`default_nettype none
module admf_mcu_model (
    input wire logic core_clk,
    input wire logic irq_out_n,
    output logic [7:0] pulse_cnt,
    output logic [7:0] pulse_len
);
    logic [7:0] run_q = 8'h00;
    initial begin
        pulse_cnt = 8'h00;
        pulse_len = 8'h00;
    end
    // A pulse is only counted once it ends, so its length is known.
    always @(posedge core_clk) begin
        if (!irq_out_n) begin
            run_q <= run_q + 8'h01;
        end else if (run_q != 8'h00) begin
            pulse_cnt <= pulse_cnt + 8'h01;
            pulse_len <= run_q;
            run_q <= 8'h00;
        end
    end
endmodule // admf_mcu_model
`default_nettype wire

// file: bench/admf_tb_top.sv
// Self-checking bench for the mode sequencer and its interrupt pulses.
`timescale 1ns/100ps
`default_nettype none
module analog_die_mode_and_fault_irq_tb_top;
    import admf_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] flt = 4'h0;
    logic [1:0] wk = 2'b00;
    logic [7:0] reg_wdata = 8'h00;
    logic watchdog_config_pin = 1'b0, direct_switch_enable = 1'b1, bus_rx = 1'b1;
    logic bus_tx = 1'b1, select_n = 1'b1;
    admf_byte_t reg_rdata;
    logic reset_out_n, irq_out_n, regulator_on, regulator_limited, switch_out_one;
    logic switch_out_two, switch_out_three, bus_tx_out, bus_rx_enable, sense_amp_on;
    logic watchdog_running;
    logic [7:0] pulse_cnt, pulse_len, n;
    logic [7:0] code [4] = '{8'h15, 8'h15, 8'h17, 8'h16};
    int errors = 0, cmp_count = 0, cyc = 0, k;
    wire logic [7:0] sw = {5'h00, switch_out_one, switch_out_two, switch_out_three};
    wire logic [7:0] st = {reset_out_n, irq_out_n, regulator_on, regulator_limited,
        bus_tx_out, sense_amp_on, watchdog_running, 1'b0};
    admf_mode_ctrl #(.WD_CYCLES(32'h000000c8), .BUS_WAKE_CYCLES(16'h0004)) DUT (
        .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .watchdog_config_pin, .direct_switch_enable, .wake_input_one(wk[0]),
        .wake_input_two(wk[1]), .bus_rx, .bus_tx, .select_n, .supply_low(flt[0]),
        .supply_high(flt[1]), .regulator_hot(flt[2]), .switch_hot(flt[3]), .reset_out_n,
        .irq_out_n, .regulator_on, .regulator_limited, .switch_out_one, .switch_out_two,
        .switch_out_three, .bus_tx_out, .bus_rx_enable, .sense_amp_on, .watchdog_running);
    admf_mcu_model mcu (.core_clk, .irq_out_n, .pulse_cnt, .pulse_len);
    always #12.5 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic at(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_rst(input int lim);
        for (int i = 0; i < lim && reset_out_n !== 1'b1; i++)
            @(posedge core_clk);
    endtask
    // One event must give exactly one pulse of fixed length.
    task automatic pulse();
        n = pulse_cnt;
        for (int i = 0; i < 80 && pulse_cnt === n; i++)
            @(posedge core_clk);
        at(4);
        chk(pulse_len, 8'h28);
        chk(pulse_cnt, n + 8'h01);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        at(60);
        chk(st, 8'h68);
        wait_rst(20);
        at(1);
        chk(st, 8'he8);
        @(posedge core_clk);
        wk <= 2'b01;
        wr(4'h0, 8'h3c);
        at(2);
        chk(st, 8'hec);
        chk(sw, 8'h07);
        @(posedge core_clk);
        direct_switch_enable <= 1'b0;
        at(3);
        chk(sw, 8'h01);
        @(posedge core_clk);
        direct_switch_enable <= 1'b1;
        rd(4'h2, 8'h01);
        @(posedge core_clk);
        bus_tx <= 1'b0;
        at(1);
        chk(8'(bus_tx_out), 8'h00);
        @(posedge core_clk);
        bus_tx <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            flt[i] <= 1'b1;
            pulse();
            rd(4'h1, 8'h01 << i);
            rd(4'h3, 8'h11 + 8'(i));
            rd(4'h3, 8'h01 + 8'(i));
            if (i == 3) chk(sw, 8'h00);
            @(posedge core_clk);
            flt[i] <= 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 8'h04);
            wr(4'h0, 8'h01);
            at(2);
            chk(st, 8'hf8);
            n = pulse_cnt;
            @(posedge core_clk);
            flt <= 4'hf;
            bus_tx <= 1'b0;
            at(50);
            chk(pulse_cnt, n);
            chk(8'(bus_tx_out), 8'h01);
            chk(8'(bus_rx_enable), 8'h01);
            @(posedge core_clk);
            flt <= 4'h0;
            bus_tx <= 1'b1;
            if (i < 2) wk[i] <= ~wk[i];
            else if (i == 2) select_n <= 1'b0;
            else bus_rx <= 1'b0;
            repeat (8) @(posedge core_clk);
            select_n <= 1'b1;
            bus_rx <= 1'b1;
            pulse();
            chk(st, 8'he8);
            rd(4'h3, code[i]);
        end
        wr(4'h0, 8'h04);
        wr(4'h0, 8'h02);
        at(2);
        chk(st, 8'h48);
        @(posedge core_clk);
        select_n <= 1'b0;
        watchdog_config_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        select_n <= 1'b1;
        at(80);
        chk(st, 8'h48);
        @(posedge core_clk);
        bus_rx <= 1'b0;
        repeat (8) @(posedge core_clk);
        bus_rx <= 1'b1;
        wait_rst(120);
        at(1);
        chk(st, 8'hea);
        for (k = 0; k < 400 && reset_out_n === 1'b1; k++)
            @(posedge core_clk);
        chk(8'(k > 185 && k < 215), 8'h01);
        // The first clear leaves Normal Request freely; a second one at once is in the closed window.
        wait_rst(120);
        at(1);
        wr(4'h0, 8'h04);
        wr(4'h0, 8'h04);
        at(2);
        chk(st, 8'h68);
        final_report();
    end
endmodule // analog_die_mode_and_fault_irq_tb_top
`default_nettype wire
